// [shared/vsf_pkg.sv]
package vsf_pkg;

    // ========================================================
    // clock and filter times
    // ========================================================
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned US_PER_S        = 1_000_000;
    localparam int unsigned OV_FILT_SHORT_US = 25;
    localparam int unsigned OV_FILT_LONG_US  = 45;
    localparam int unsigned UV_FILT_0_US     = 5;
    localparam int unsigned UV_FILT_1_US     = 15;
    localparam int unsigned UV_FILT_2_US     = 25;
    localparam int unsigned UV_FILT_3_US     = 40;
    localparam int unsigned KICK_FILT_US     = 10;

    // ========================================================
    // register map (byte addresses)
    // ========================================================
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_REACT  = 8'h00;
    localparam logic [7:0]  ADDR_SCALE  = 8'h04;
    localparam logic [7:0]  ADDR_OTP    = 8'h08;
    localparam logic [7:0]  ADDR_THRESH = 8'h0c;
    localparam logic [7:0]  ADDR_FLAGS  = 8'h10;
    localparam logic [7:0]  ADDR_STATUS = 8'h14;

    // reaction fields: two bits per filter, ov at even filter index
    localparam logic [11:0] REACT_RESET = 12'h666;
    localparam int          REACT_BOTH_BIT = 1;

    // scaling register fields
    localparam int SCL_OFF_LSB = 0;
    localparam int SCL_INV_LSB = 8;
    localparam int SCL_POL_BIT = 16;

    // programmed configuration register fields
    localparam int OTP_ALT_BIT    = 0;
    localparam int OTP_KPOL_BIT   = 1;
    localparam int OTP_OVSEL_LSB  = 2;
    localparam int OTP_UVSEL_LSB  = 5;
    localparam int OTP_IOSRC_LSB  = 11;
    localparam int OTP_HVMODE_BIT = 14;
    localparam int OTP_HVLVL_BIT  = 15;
    localparam int OTP_SIGNED_BIT = 16;
    localparam int OTP_CLAMP_LSB  = 17;
    localparam logic [22:0] OTP_RESET = 23'h7e0000;

    // flag and status fields
    localparam int FLG_KICK_BIT  = 6;
    localparam int FLG_SCERR_BIT = 7;
    localparam int FLG_LIVE_LSB  = 8;
    localparam int STS_HVREF_LSB = 8;
    localparam int STS_DEEP_BIT  = 10;

    // threshold mapping in tenths of a percent
    localparam logic [7:0] TH_BASE = 8'h19;
    localparam logic [7:0] TH_STEP = 8'h05;

    localparam int         NUM_MON     = 3;
    localparam int         NUM_FILT    = 6;
    localparam logic [2:0] IO_SRC_EXTERNAL = 3'h7;
    localparam logic [1:0] HVREF_0V8   = 2'h0;
    localparam logic [1:0] HVREF_3V3   = 2'h1;
    localparam logic [1:0] HVREF_TRACK = 2'h2;

    typedef struct packed {
        logic uv;
        logic ov;
    } vsf_mon_type;

    typedef struct packed {
        logic [7:0] ov;
        logic [7:0] uv;
    } vsf_th_type;

    typedef struct packed {
        logic       negative;
        logic [5:0] steps;
    } vsf_scale_type;

    typedef enum logic [2:0] {
        KICK_IDLE    = 3'b001,
        KICK_DEEP    = 3'b010,
        KICK_RESTART = 3'b100
    } vsf_kick_type;

endpackage

// [testbench/tb_top.sv]
`timescale 1ns/1ps
// ========================================================
// bench: register port, rails and kick pin
module tb_top;
    localparam int unsigned HZ = 1_000_000; // one cycle per microsecond
    logic        clk_sys = 1'h0, reset_n = 1'h0, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0, initPh = 1'h0;
    logic        fsAct = 1'h0, kickReq = 1'h0, kickPol = 1'h1;
    logic        pready, pslverr, reset_out_n, failsafe_out_n;
    logic        coreBuckOff, deepFailsafe, fault_input_one;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [5:0]  railFault = 6'h0, off;
    logic [32:0] expQ[$];
    int          errTotal = 0, checksDone = 0, cycles = 0, t;
    vsf_pkg::vsf_mon_type [2:0] monitorRaw;
    vsf_pkg::vsf_scale_type     scaleTarget;

    initial forever #20 clk_sys = ~clk_sys;

    vsf_far_side u_far (.kickReq(kickReq), .kickPol(kickPol),
        .railFault(railFault), .monitorRaw(monitorRaw),
        .fault_input_one(fault_input_one));
    vsf_voltage_supervisor #(.CLK_HZ(HZ)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .safety_init_phase(initPh),
        .failsafe_active(fsAct), .monitorRaw(monitorRaw),
        .fault_input_one(fault_input_one), .reset_out_n(reset_out_n),
        .failsafe_out_n(failsafe_out_n), .faultCountInc(),
        .coreBuckOff(coreBuckOff), .hvRegOff(), .ioRegOff(),
        .deepFailsafe(deepFailsafe), .appRestart(),
        .scaleTarget(scaleTarget), .scaleStart(), .coreTh(), .ioTh(),
        .hvTh(), .hvRefSel());

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // idle edge after release: psel never driven twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask

    task automatic scl(input logic [5:0] o, input logic [5:0] n,
                       input logic p);
        apb(1'h1, vsf_pkg::ADDR_SCALE, {15'h0, p, 2'h0, n, 2'h0, o});
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic tallyAndFinish();
        if (errTotal == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // reads compare against the oldest note
    always @(posedge clk_sys)
        if (psel && penable && pready && !pwrite && expQ.size() > 0)
            chk({pslverr, prdata}, expQ.pop_front());

    // a hang ends the run as a failure
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errTotal++;
            tallyAndFinish();
        end
    end

    initial begin
        void'($urandom(19));
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'h1;
        @(posedge clk_sys);
        apb(1'h1, vsf_pkg::ADDR_REACT, 32'h0);
        rd(vsf_pkg::ADDR_REACT, 33'h666);
        rd(vsf_pkg::ADDR_OTP, 33'h7e0000);
        rd(8'h18, 33'h100000000);
        railFault <= 6'h1;
        repeat (60) @(posedge clk_sys);
        chk(coreBuckOff, 1'h0);
        rd(vsf_pkg::ADDR_FLAGS, 33'h0);
        railFault <= 6'h0;
        fsAct     <= 1'h1;
        initPh    <= 1'h1;
        // every reaction code, both overvoltage filter settings
        for (int c = 0; c < 4; c++) begin
            apb(1'h1, vsf_pkg::ADDR_REACT, 32'h664 | c);
            apb(1'h1, vsf_pkg::ADDR_OTP, 32'h7e0000 | {29'h0, c[0], 2'h0});
            t = c[0] ? 45 : 25;
            railFault <= 6'h1;
            repeat (t - 3) @(posedge clk_sys);
            chk(coreBuckOff, 1'h0);
            repeat (9) @(posedge clk_sys);
            chk(coreBuckOff, 1'h1);
            chk(failsafe_out_n, c == 0);
            chk(reset_out_n, c < 2);
            railFault <= 6'h0;
            repeat (8) @(posedge clk_sys);
            chk(coreBuckOff, 1'h0);
            rd(vsf_pkg::ADDR_FLAGS, 33'h1);
            apb(1'h1, vsf_pkg::ADDR_FLAGS, 32'h1);
            rd(vsf_pkg::ADDR_FLAGS, 33'h0);
        end
        off = 6'($urandom);
        scl(off, ~off, 1'h0);
        chk(scaleTarget, {1'h1, off});
        scl(off ^ 6'h1, off ^ 6'h1, 1'h0);
        chk(scaleTarget, {1'h1, off});
        rd(vsf_pkg::ADDR_FLAGS, 33'h80);
        apb(1'h1, vsf_pkg::ADDR_OTP, 32'h7f0000);
        scl(6'h0, 6'h3f, 1'h1);
        scl(off, ~off, 1'h1);
        chk(scaleTarget, {1'h0, off});
        apb(1'h1, vsf_pkg::ADDR_OTP, 32'h10000);
        scl(off ^ 6'h1, ~(off ^ 6'h1), 1'h1);
        chk(scaleTarget, {1'h0, off});
        // short kick is filtered, long kick reaches deep fail-safe
        apb(1'h1, vsf_pkg::ADDR_OTP, 32'h7e0003);
        kickReq <= 1'h1;
        repeat (5) @(posedge clk_sys);
        kickReq <= 1'h0;
        repeat (20) @(posedge clk_sys);
        chk(deepFailsafe, 1'h0);
        kickReq <= 1'h1;
        repeat (20) @(posedge clk_sys);
        chk({deepFailsafe, reset_out_n}, 2'h2);
        kickReq <= 1'h0;
        repeat (20) @(posedge clk_sys);
        chk(deepFailsafe, 1'h0);
        tallyAndFinish();
    end
endmodule

// [testbench/vsf_far_side.sv]
`timescale 1ns/1ps
// ========================================================
// host fault pin and rail comparators
module vsf_far_side (
    input  wire logic                  kickReq,
    input  wire logic                  kickPol,
    input  wire logic [5:0]            railFault,
    output vsf_pkg::vsf_mon_type [2:0] monitorRaw,
    output logic                       fault_input_one
);
    // comparators follow the rail; the pin rests at its inactive level
    assign monitorRaw      = railFault;
    assign fault_input_one = kickReq ? kickPol : ~kickPol;
endmodule

// [testbench/vsf_supervisor_asserts.sv]
`timescale 1ns/1ps
// ========================================================
// port checks of the supervisor
module vsf_supervisor_asserts #(
    parameter int unsigned CLK_HZ = vsf_pkg::CLK_HZ
) (
    input wire logic                       clk_sys,
    input wire logic                       reset_n,
    input wire logic [31:0]                pwdata,
    input wire logic                       failsafe_active,
    input wire vsf_pkg::vsf_mon_type [2:0] monitorRaw,
    input wire logic                       reset_out_n,
    input wire logic                       failsafe_out_n,
    input wire logic                       faultCountInc,
    input wire logic                       coreBuckOff,
    input wire logic                       deepFailsafe,
    input wire logic                       appRestart,
    input wire vsf_pkg::vsf_scale_type     scaleTarget,
    input wire logic                       scaleStart
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // filters clear at once, the outputs follow a cycle later
    property p_idle; !failsafe_active [*3] |-> !coreBuckOff; endproperty
    a_idle: assert property (p_idle)
        else $error("regulator off while unsupervised");
    // the filter needs far more than 5 cycles, so the raw run covers it
    property p_ov; $rose(coreBuckOff) |-> $past(monitorRaw[0].ov, 5);
    endproperty
    a_ov: assert property (p_ov)
        else $error("regulator off without overvoltage");
    property p_both; !reset_out_n |-> !failsafe_out_n; endproperty
    a_both: assert property (p_both)
        else $error("reset without fail-safe");
    property p_cnt; faultCountInc |-> ##[0:2] !failsafe_out_n; endproperty
    a_cnt: assert property (p_cnt)
        else $error("fault counted without reaction");
    property p_hold; $changed(scaleTarget) |-> scaleStart; endproperty
    a_hold: assert property (p_hold)
        else $error("scaling target moved without start");
    // the pulse follows the completing write edge by one cycle
    property p_match;
        scaleStart |-> $past(pwdata[13:8]) == ~$past(pwdata[5:0])
            && scaleTarget.steps == $past(pwdata[5:0]);
    endproperty
    a_match: assert property (p_match)
        else $error("scaling started on bad complement");
    property p_deep;
        $rose(deepFailsafe) |-> ##[0:1] (!reset_out_n && !failsafe_out_n);
    endproperty
    a_deep: assert property (p_deep)
        else $error("deep fail-safe without both outputs");
    property p_rest; $fell(deepFailsafe) |-> ##[0:2] appRestart; endproperty
    a_rest: assert property (p_rest)
        else $error("no restart after deep fail-safe");
endmodule

bind vsf_voltage_supervisor
    vsf_supervisor_asserts #(.CLK_HZ(CLK_HZ)) u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .pwdata(pwdata),
    .failsafe_active(failsafe_active), .monitorRaw(monitorRaw),
    .reset_out_n(reset_out_n), .failsafe_out_n(failsafe_out_n),
    .faultCountInc(faultCountInc), .coreBuckOff(coreBuckOff),
    .deepFailsafe(deepFailsafe), .appRestart(appRestart),
    .scaleTarget(scaleTarget), .scaleStart(scaleStart));

// [verilog/vsf_voltage_supervisor.sv]
`timescale 1ns/1ps
// Functional notes
// - alternate bit makes fault_input_one a polarity-set kick pin.
// - asserted kick pin sends state to deep fail-safe, then restart.
// - kick pin is debounced for 10 us before acting.
// - own-regulator overvoltage switches it off until clear.
// - rail supervision and its flags only while failsafe_active equals 1.
// - core reactions writable in init phase only; reset defaults.
// - core ov reaction: 00 none, 01 fail-safe, 1x both; default 10.
// - core uv reaction: same encoding, default 01.
// - io ov/uv reactions same encoding; ov default 10, uv 01.
// - ov deglitch 25 or 45 us selected by one bit.
// - uv deglitch 5, 15, 25 or 40 us selected by two bits.
// - threshold code maps to 2.5..10 percent in 0.5 percent steps.
// - six-bit offset counts 6.25 mV steps, default zero.
// - output change starts only on a matching complement.
// - mismatched complement skips scaling, output unchanged.
// - clamp mask limits steps; all zero disables scaling.
// - signed-range bit allows polarity bit to add or subtract.
// - thresholds follow the threshold register only, not the scaling target.
// - io source select names regulator to cut; external never.
// - hv reference tracks dac in switch mode, else 0.8 or 3.3 V.
// - hv reactions same encoding; uv default 01, ov default 10.
// - fault with no output reaction only sets flag, no count.
module vsf_voltage_supervisor #(
    parameter int unsigned CLK_HZ = vsf_pkg::CLK_HZ
) (
    input  wire logic                                   clk_sys,
    input  wire logic                                   reset_n,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [vsf_pkg::ADDR_W-1:0]             paddr,
    input  wire logic [31:0]                            pwdata,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic                                   safety_init_phase,
    input  wire logic                                   failsafe_active,
    input  wire vsf_pkg::vsf_mon_type [vsf_pkg::NUM_MON-1:0] monitorRaw,
    input  wire logic                                   fault_input_one,
    output logic                                        reset_out_n,
    output logic                                        failsafe_out_n,
    output logic                                        faultCountInc,
    output logic                                        coreBuckOff,
    output logic                                        hvRegOff,
    output logic      [6:0]                             ioRegOff,
    output logic                                        deepFailsafe,
    output logic                                        appRestart,
    output vsf_pkg::vsf_scale_type                      scaleTarget,
    output logic                                        scaleStart,
    output vsf_pkg::vsf_th_type                         coreTh,
    output vsf_pkg::vsf_th_type                         ioTh,
    output vsf_pkg::vsf_th_type                         hvTh,
    output logic      [1:0]                             hvRefSel
);

    // ========================================================
    // cycle counts
    // ========================================================
    localparam int CNT_W = 11;
    localparam int unsigned CYC_US = CLK_HZ / vsf_pkg::US_PER_S;
    function automatic logic [CNT_W-1:0] usCyc(input int unsigned us);
        return CNT_W'(us * CYC_US);
    endfunction
    localparam OV_SHORT_CYC = usCyc(vsf_pkg::OV_FILT_SHORT_US);
    localparam OV_LONG_CYC  = usCyc(vsf_pkg::OV_FILT_LONG_US);
    localparam KICK_CYC     = usCyc(vsf_pkg::KICK_FILT_US);
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam int NF = vsf_pkg::NUM_FILT;

    // ========================================================
    // registers
    // ========================================================
    logic [11:0]   react_q;
    logic [22:0]   otp_q;
    logic [23:0]   thCode_q;
    logic [5:0]    sclOff_q;
    logic [5:0]    sclInv_q;
    logic          sclPol_q;
    logic [7:0]    flag_q;
    logic [31:0]   rdata;
    logic          rdErr;
    logic          wrDone;
    logic          setupSeen;
    logic [NF-1:0] filt_q;
    assign setupSeen = psel & penable & ~pready;
    assign wrDone    = psel & penable & pready & pwrite;

    // apb answers one cycle into the access phase
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupSeen;
            pslverr <= setupSeen & rdErr;
            if (setupSeen && !pwrite) begin
                prdata <= rdata;
            end
        end
    end

    // read decode; unmapped addresses answer zero with an error
    always_comb begin
        rdata = 32'h0000_0000;
        rdErr = 1'b0;
        if (paddr == vsf_pkg::ADDR_REACT) begin
            rdata[11:0] = react_q;
        end else if (paddr == vsf_pkg::ADDR_SCALE) begin
            rdata[vsf_pkg::SCL_OFF_LSB +: 6] = sclOff_q;
            rdata[vsf_pkg::SCL_INV_LSB +: 6] = sclInv_q;
            rdata[vsf_pkg::SCL_POL_BIT]      = sclPol_q;
        end else if (paddr == vsf_pkg::ADDR_OTP) begin
            rdata[22:0] = otp_q;
        end else if (paddr == vsf_pkg::ADDR_THRESH) begin
            rdata[23:0] = thCode_q;
        end else if (paddr == vsf_pkg::ADDR_FLAGS) begin
            rdata[7:0] = flag_q;
            rdata[vsf_pkg::FLG_LIVE_LSB +: NF] = filt_q;
        end else if (paddr == vsf_pkg::ADDR_STATUS) begin
            rdata[6:0] = scaleTarget;
            rdata[vsf_pkg::STS_HVREF_LSB +: 2] = hvRefSel;
            rdata[vsf_pkg::STS_DEEP_BIT] = deepFailsafe;
        end else begin
            rdErr = 1'b1;
        end
    end

    // reaction fields only move while the safety init phase is open
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            react_q <= vsf_pkg::REACT_RESET;
        end else if (wrDone && paddr == vsf_pkg::ADDR_REACT
                     && safety_init_phase) begin
            react_q <= pwdata[11:0];
        end
    end

    // programmed settings and threshold codes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            otp_q    <= vsf_pkg::OTP_RESET;
            thCode_q <= 24'h00_0000;
        end else if (wrDone && paddr == vsf_pkg::ADDR_OTP) begin
            otp_q <= pwdata[22:0];
        end else if (wrDone && paddr == vsf_pkg::ADDR_THRESH) begin
            thCode_q <= pwdata[23:0];
        end
    end

    // ========================================================
    // input synchronisers
    // ========================================================
    logic [NF:0] syncA_q;
    logic [NF:0] syncB_q;
    logic [NF-1:0] rawS;
    logic          pinS;
    // comparator outputs and the pin come from outside this domain
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {fault_input_one, monitorRaw};
            syncB_q <= syncA_q;
        end
    end
    assign rawS = syncB_q[NF-1:0];
    assign pinS = syncB_q[NF];
    // ========================================================
    // deglitch filters, ov at even index, uv at odd index
    // ========================================================
    logic [CNT_W-1:0] filtTarget [NF];
    logic [NF-1:0]    filtPrev_q;
    function automatic logic [CNT_W-1:0] uvTarget(input logic [1:0] sel);
        logic [CNT_W-1:0] t;
        case (sel)
            2'h0:    t = usCyc(vsf_pkg::UV_FILT_0_US);
            2'h1:    t = usCyc(vsf_pkg::UV_FILT_1_US);
            2'h2:    t = usCyc(vsf_pkg::UV_FILT_2_US);
            default: t = usCyc(vsf_pkg::UV_FILT_3_US);
        endcase
        return t;
    endfunction
    // filter length per monitor from the programmed selects
    always_comb begin
        for (int m = 0; m < vsf_pkg::NUM_MON; m++) begin
            filtTarget[2*m] = otp_q[vsf_pkg::OTP_OVSEL_LSB + m] ?
                              OV_LONG_CYC : OV_SHORT_CYC;
            filtTarget[2*m+1] =
                uvTarget(otp_q[vsf_pkg::OTP_UVSEL_LSB + 2*m +: 2]);
        end
    end

    for (genvar f = 0; f < NF; f++) begin : g_filt
        logic [CNT_W-1:0] cnt_q;
        // a drop of the raw level restarts the count from zero
        always_ff @(posedge clk_sys) begin
            if (!reset_n || !failsafe_active) begin
                cnt_q     <= '0;
                filt_q[f] <= 1'b0;
            end else if (!rawS[f]) begin
                cnt_q     <= '0;
                filt_q[f] <= 1'b0;
            end else if (cnt_q >= filtTarget[f] - CNT_ONE) begin
                filt_q[f] <= 1'b1;
            end else begin
                cnt_q <= cnt_q + CNT_ONE;
            end
        end
    end

    // ========================================================
    // fault reactions
    // ========================================================
    logic [NF-1:0] reactAny;
    logic [NF-1:0] reactBoth;
    logic          kickFault;
    // 01 gives fail-safe only, 1x gives reset as well
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            reactAny[f]  = |react_q[2*f +: 2];
            reactBoth[f] = react_q[2*f + vsf_pkg::REACT_BOTH_BIT];
        end
    end

    // outputs follow the filtered faults; deep fail-safe forces both
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reset_out_n    <= 1'b1;
            failsafe_out_n <= 1'b1;
            faultCountInc  <= 1'b0;
            filtPrev_q     <= '0;
        end else begin
            filtPrev_q     <= filt_q;
            failsafe_out_n <= ~(|(filt_q & reactAny) | kickFault);
            reset_out_n    <= ~(|(filt_q & reactBoth) | kickFault);
            // unreacted faults only flag, the counter never sees them
            faultCountInc  <= |(filt_q & ~filtPrev_q & reactAny);
        end
    end

    // regulator shutdown lasts exactly as long as the filtered ov flag, one cycle behind it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            coreBuckOff <= 1'b0;
            hvRegOff    <= 1'b0;
            ioRegOff    <= 7'h00;
        end else begin
            coreBuckOff <= filt_q[0];
            hvRegOff    <= filt_q[4];
            if (filt_q[2] && otp_q[vsf_pkg::OTP_IOSRC_LSB +: 3]
                             != vsf_pkg::IO_SRC_EXTERNAL) begin
                ioRegOff <= 7'(7'h01 << otp_q[vsf_pkg::OTP_IOSRC_LSB +: 3]);
            end else begin
                ioRegOff <= 7'h00;
            end
        end
    end

    // ========================================================
    // alternate kick pin use of fault_input_one
    // ========================================================
    logic             kickLvl;
    logic             kickDeb_q;
    logic [CNT_W-1:0] kickCnt_q;
    vsf_pkg::vsf_kick_type kickState_q;
    // asserted when the pin equals the programmed polarity
    assign kickLvl = otp_q[vsf_pkg::OTP_ALT_BIT]
                   & (pinS == otp_q[vsf_pkg::OTP_KPOL_BIT]);
    assign kickFault = deepFailsafe;

    // debounce both ways so a short spike neither sets nor clears
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            kickCnt_q <= '0;
            kickDeb_q <= 1'b0;
        end else if (kickLvl == kickDeb_q) begin
            kickCnt_q <= '0;
        end else if (kickCnt_q >= KICK_CYC - CNT_ONE) begin
            kickCnt_q <= '0;
            kickDeb_q <= kickLvl;
        end else begin
            kickCnt_q <= kickCnt_q + CNT_ONE;
        end
    end

    // deep fail-safe holds until the pin releases, then one restart
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            kickState_q  <= vsf_pkg::KICK_IDLE;
            deepFailsafe <= 1'b0;
            appRestart   <= 1'b0;
        end else begin
            appRestart <= 1'b0;
            case (kickState_q)
                vsf_pkg::KICK_IDLE: begin
                    if (kickDeb_q) begin
                        kickState_q  <= vsf_pkg::KICK_DEEP;
                        deepFailsafe <= 1'b1;
                    end
                end
                vsf_pkg::KICK_DEEP: begin
                    if (!kickDeb_q) begin
                        kickState_q  <= vsf_pkg::KICK_RESTART;
                        deepFailsafe <= 1'b0;
                        appRestart   <= 1'b1;
                    end
                end
                default: begin
                    kickState_q <= vsf_pkg::KICK_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // static scaling and flags
    // ========================================================
    logic       sclWr;
    logic [5:0] wrOff;
    logic [5:0] wrInv;
    logic [5:0] clamp;
    logic       sclOk;
    logic       sclBad;
    assign clamp = otp_q[vsf_pkg::OTP_CLAMP_LSB +: 6];
    assign wrOff = pwdata[vsf_pkg::SCL_OFF_LSB +: 6];
    assign wrInv = pwdata[vsf_pkg::SCL_INV_LSB +: 6];
    // host keeps to the init phase; later writes are simply dropped
    assign sclWr = wrDone && paddr == vsf_pkg::ADDR_SCALE
                 && safety_init_phase;
    assign sclOk = (wrInv == ~wrOff)
                 && (clamp != 6'h00) && ((wrOff & ~clamp) == 6'h00);
    assign sclBad = sclWr & ~sclOk;

    // target moves alone on the write edge; thresholds keep their codes, so the ramp must
    // settle within the filter time; big moves belong in small writes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sclOff_q    <= 6'h00;
            sclInv_q    <= 6'h3f;
            sclPol_q    <= 1'b0;
            scaleTarget <= '0;
            scaleStart  <= 1'b0;
        end else begin
            scaleStart <= sclWr & sclOk;
            if (sclWr) begin
                sclOff_q <= wrOff;
                sclInv_q <= wrInv;
                sclPol_q <= pwdata[vsf_pkg::SCL_POL_BIT];
            end
            if (sclWr && sclOk) begin
                scaleTarget.steps    <= wrOff;
                scaleTarget.negative <= ~(otp_q[vsf_pkg::OTP_SIGNED_BIT]
                    & pwdata[vsf_pkg::SCL_POL_BIT]);
            end
        end
    end

    // sticky flags, write one to clear, a new event beats the clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flag_q <= 8'h00;
        end else begin
            flag_q <= (flag_q & ~((wrDone && paddr == vsf_pkg::ADDR_FLAGS)
                                  ? pwdata[7:0] : 8'h00))
                    | {sclBad, deepFailsafe, filt_q};
        end
    end

    // ========================================================
    // thresholds and hv reference
    // ========================================================
    function automatic logic [7:0] thMap(input logic [3:0] code);
        return vsf_pkg::TH_BASE + 8'(vsf_pkg::TH_STEP * code);
    endfunction
    // codes packed ov then uv per monitor, core first
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            coreTh   <= '0;
            ioTh     <= '0;
            hvTh     <= '0;
            hvRefSel <= vsf_pkg::HVREF_0V8;
        end else begin
            coreTh <= {thMap(thCode_q[3:0]), thMap(thCode_q[7:4])};
            ioTh   <= {thMap(thCode_q[11:8]), thMap(thCode_q[15:12])};
            hvTh   <= {thMap(thCode_q[19:16]), thMap(thCode_q[23:20])};
            hvRefSel <= otp_q[vsf_pkg::OTP_HVMODE_BIT] ? vsf_pkg::HVREF_TRACK
                      : otp_q[vsf_pkg::OTP_HVLVL_BIT] ? vsf_pkg::HVREF_3V3
                      : vsf_pkg::HVREF_0V8;
        end
    end

endmodule
